// file: rtl/nip_arbiter.sv
// Two-step arbiter: software rank first, lowest vector index breaks ties
// Purely combinational; used inside the controller
`timescale 1ns/1ps
module nip_arbiter
  import nip_pkg::*;
#(
  parameter int NVEC = NIP_NVEC
)(
  input  wire logic [NVEC-1:0]   req,
  input  wire logic [2*NVEC-1:0] lvl,
  input  wire logic [1:0]        cur,
  output logic                   valid,
  output logic [3:0]             idx
);
  logic [1:0] best;
  logic [1:0] r;

  always_comb
  begin
    best  = 2'b00;
    r     = 2'b00;
    valid = 1'b0;
    idx   = 4'h0;
    for (int i = NVEC - 1; i >= 0; i--)
    begin
      r = nip_rank(lvl[2*i +: 2]);
      if (req[i] && r > nip_rank(cur) && (!valid || r >= best))
      begin
        valid = 1'b1;
        best  = r;
        idx   = 4'(i);
      end
    end
  end
endmodule

// file: rtl/nip_ctrl.sv
// Nested priority interrupt controller with AHB-Lite register port
// Assumes CPU handshake strobes are one-cycle pulses synchronous to hclk
//
// Overview of operation
// - Take interrupts only at instruction boundary
// - Push PC, X, A, CC on entry
// - Load level bits from vector's stored level
// - Then load vector address into program counter
// - Return pops everything, restoring level bits
// - Codes: L0=10, L1=01, L2=00, L3=11
// - Highest software level wins first
// - Ties go to highest hardware priority
// - Unserviced requests stay latched until they win (code latches only edge requests; level requests follow the source)
// - Reset and trap outrank all requests
// - Trap and reset ignore mask, force level 3
// - Reset and trap wake from Halt
// - Trap instruction raises non-maskable software interrupt
// - Maskable needs enable and level above current
// - Edge requests latched, cleared on handler entry
// - Selected pins of a group are ORed
// - Peripheral request is flag AND enable
// - Clearing sequence discards the latched request
// - Any source wakes from Wait
// - After Halt, first service must be wake-capable
// - Hardware priority: group zero highest, main lowest
// - Concurrent or nested mode, software selectable
// - Level 0 writes to a field are ignored
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module nip_ctrl
  import nip_pkg::*;
#(
  parameter int NVEC = NIP_NVEC,
  parameter int NEXT = NIP_NEXT,
  parameter int NPIN = NIP_NPIN
)(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [NPIN-1:0]  ext_pin,
  input  wire logic [NVEC-NEXT-1:0] periph_flag,
  input  wire logic [NVEC-1:0]  periph_clear,
  input  wire logic             instr_done,
  input  wire logic             trap_exec,
  input  wire logic             handler_return_instr_exec,
  input  wire logic [1:0]       handler_return_instr_level,
  input  wire logic             cpu_halt,
  input  wire logic             cpu_wait,
  output logic                  stack_push,
  output logic      [1:0]       stack_item,
  output logic                  vector_load,
  output logic      [15:0]      vector_addr,
  output logic                  level_bit_high,
  output logic                  level_bit_low,
  output logic                  entry_busy,
  output logic                  wake
);
  localparam int GPIN = NPIN / NEXT;

  // Register file
  logic [2*NVEC-1:0] lvl_regs_ff;
  logic [NEXT-1:0]   edge_ff;
  logic [NVEC-1:0]   en_ff;
  logic              nest_ff;
  logic [NPIN-1:0]   psel_ff;
  logic [NVEC-1:0]   wcap_ff;
  // Bus phase
  logic              wr_pend_ff;
  logic              rd_pend_ff;
  logic [7:0]        addr_ff;
  logic [31:0]       hrdata_ff;
  logic              hreadyout_ff;
  logic [31:0]       rd_mux;
  logic              acc;
  // Sequencer
  nip_state_t        state_ff;
  logic              busy_ff;
  logic [1:0]        item_ff;
  logic              rst_vec_ff;
  logic              sel_trap_ff;
  logic [3:0]        sel_idx_ff;
  logic              trap_pend_ff;
  logic              halt_first_ff;
  logic [1:0]        cc_lvl_ff;
  logic [3:0]        depth_ff;
  logic              stack_push_ff;
  logic [1:0]        stack_item_ff;
  logic              vector_load_ff;
  logic [15:0]       vector_addr_ff;
  logic              wake_ff;
  // Requests
  logic [NVEC-1:0]   src;
  logic [NVEC-1:0]   pend;
  logic [NVEC-1:0]   clr_entry;
  logic [NVEC-1:0]   elig;
  logic              win_valid;
  logic [3:0]        win_idx;
  logic              start;

  assign acc = hsel && hready && htrans[1];

  // Request sources
  always_comb
  begin
    src = '0;
    for (int g = 0; g < NEXT; g++)
      src[g] = |(ext_pin[g*GPIN +: GPIN] & psel_ff[g*GPIN +: GPIN]);
    for (int p = NEXT; p < NVEC; p++)
      src[p] = periph_flag[p-NEXT] && en_ff[p];
  end

  always_comb
  begin
    clr_entry = '0;
    if (state_ff == NIP_ST_LOAD && !rst_vec_ff && !sel_trap_ff)
      clr_entry[sel_idx_ff] = 1'b1;
  end

  genvar gv;
  generate
    for (gv = 0; gv < NVEC; gv++)
    begin : g_lat
      nip_req_latch u_lat (
        .clk       (hclk),
        .rst_n     (hresetn),
        .src       (src[gv]),
        .edge_mode ((gv < NEXT) ? edge_ff[gv % NEXT] : 1'b0),
        .clr_entry (clr_entry[gv]),
        .clr_seq   (periph_clear[gv]),
        .pend      (pend[gv])
      );
    end
  endgenerate

  // Eligibility: enabled, mode allows, and post-Halt wake filter
  always_comb
  begin
    elig = pend & en_ff;
    if (!nest_ff && depth_ff != 4'h0)
      elig = '0;
    if (cpu_halt || halt_first_ff)
      elig = elig & wcap_ff;
  end

  nip_arbiter #(
    .NVEC (NVEC)
  ) u_arb (
    .req   (elig),
    .lvl   (lvl_regs_ff),
    .cur   (cc_lvl_ff),
    .valid (win_valid),
    .idx   (win_idx)
  );

  // Trap and reset are taken ahead of any maskable winner
  assign start = (state_ff == NIP_ST_IDLE) && instr_done
                 && (trap_pend_ff || win_valid);

  // Bus phase tracking; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      addr_ff      <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= acc && hwrite;
      rd_pend_ff <= acc && !hwrite;
      if (acc)
        addr_ff <= haddr[7:0];
      if (acc && !hwrite)
        hreadyout_ff <= 1'b0;
      else
        hreadyout_ff <= 1'b1;
      if (rd_pend_ff)
        hrdata_ff <= rd_mux;
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_ff == NIP_OFS_LVL0)
      rd_mux[7:0] = lvl_regs_ff[7:0];
    else if (addr_ff == NIP_OFS_LVL1)
      rd_mux[7:0] = lvl_regs_ff[15:8];
    else if (addr_ff == NIP_OFS_LVL2)
      rd_mux[7:0] = lvl_regs_ff[23:16];
    else if (addr_ff == NIP_OFS_LVL3)
      rd_mux[3:0] = lvl_regs_ff[27:24];
    else if (addr_ff == NIP_OFS_EDGE)
      rd_mux[NEXT-1:0] = edge_ff;
    else if (addr_ff == NIP_OFS_EN)
      rd_mux[NVEC-1:0] = en_ff;
    else if (addr_ff == NIP_OFS_CTRL)
      rd_mux[NIP_CTRL_NEST] = nest_ff;
    else if (addr_ff == NIP_OFS_PSEL)
      rd_mux[NPIN-1:0] = psel_ff;
    else if (addr_ff == NIP_OFS_STAT)
    begin
      rd_mux[NVEC-1:0] = pend;
      rd_mux[NIP_STAT_LVL +: 2] = cc_lvl_ff;
      rd_mux[NIP_STAT_DEP +: 4] = depth_ff;
      rd_mux[NIP_STAT_BUSY] = (state_ff != NIP_ST_IDLE);
    end
    else if (addr_ff == NIP_OFS_WCAP)
      rd_mux[NVEC-1:0] = wcap_ff;
  end

  // Vector level registers, level 0 fields keep their old value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lvl_regs_ff <= NIP_RST_LVL[2*NVEC-1:0];
    else if (wr_pend_ff && addr_ff[7:4] == 4'h0)
    begin
      for (int f = 0; f < 4; f++)
      begin
        if (4 * int'(addr_ff[3:2]) + f < NVEC
            && hwdata[2*f +: 2] != NIP_LVL_0)
          lvl_regs_ff[8*addr_ff[3:2] + 2*f +: 2] <= hwdata[2*f +: 2];
      end
    end
  end

  // Control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      edge_ff <= NIP_RST_EDGE;
      en_ff   <= NIP_RST_EN;
      nest_ff <= NIP_RST_NEST;
      psel_ff <= NIP_RST_PSEL;
      wcap_ff <= NIP_RST_WCAP;
    end
    else if (wr_pend_ff)
    begin
      if (addr_ff == NIP_OFS_EDGE)
        edge_ff <= hwdata[NEXT-1:0];
      else if (addr_ff == NIP_OFS_EN)
        en_ff <= hwdata[NVEC-1:0];
      else if (addr_ff == NIP_OFS_CTRL)
        nest_ff <= hwdata[NIP_CTRL_NEST];
      else if (addr_ff == NIP_OFS_PSEL)
        psel_ff <= hwdata[NPIN-1:0];
      else if (addr_ff == NIP_OFS_WCAP)
        wcap_ff <= hwdata[NVEC-1:0];
    end
  end

  // Trap request latch, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      trap_pend_ff <= 1'b0;
    else if (trap_exec)
      trap_pend_ff <= 1'b1;
    else if (start)
      trap_pend_ff <= 1'b0;
  end

  // Halt wake filter stays on until the first entry after Halt
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      halt_first_ff <= 1'b0;
    else if (cpu_halt && (win_valid || trap_pend_ff))
      halt_first_ff <= 1'b1;
    else if (start)
      halt_first_ff <= 1'b0;
  end

  // Wake request toward the core
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wake_ff <= 1'b0;
    else
      wake_ff <= (cpu_halt && (win_valid || trap_pend_ff))
                 || (cpu_wait && (|pend || trap_pend_ff));
  end

  // Entry sequencer; reset vector fetch runs without stacking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff    <= NIP_ST_LOAD;
      busy_ff     <= 1'b1;
      rst_vec_ff  <= 1'b1;
      sel_trap_ff <= 1'b0;
      sel_idx_ff  <= 4'h0;
      item_ff     <= NIP_ITEM_PC;
    end
    else
    begin
      // Busy flop mirrors the next state so the output needs no decode
      busy_ff <= (state_ff == NIP_ST_IDLE) ? start : (state_ff == NIP_ST_PUSH);
      case (state_ff)
        NIP_ST_IDLE:
        begin
          if (start)
          begin
            state_ff    <= NIP_ST_PUSH;
            item_ff     <= NIP_ITEM_PC;
            sel_trap_ff <= trap_pend_ff;
            sel_idx_ff  <= win_idx;
          end
        end
        NIP_ST_PUSH:
        begin
          item_ff <= item_ff + 2'b01;
          if (item_ff == NIP_ITEM_CC)
            state_ff <= NIP_ST_LOAD;
        end
        NIP_ST_LOAD:
        begin
          state_ff   <= NIP_ST_IDLE;
          rst_vec_ff <= 1'b0;
        end
        default:
          state_ff <= NIP_ST_IDLE;
      endcase
    end
  end

  // Stack push strobes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stack_push_ff <= 1'b0;
      stack_item_ff <= NIP_ITEM_PC;
    end
    else
    begin
      stack_push_ff <= (state_ff == NIP_ST_PUSH);
      stack_item_ff <= item_ff;
    end
  end

  // Vector load after stacking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_load_ff <= 1'b0;
      vector_addr_ff <= NIP_VEC_RST;
    end
    else
    begin
      vector_load_ff <= (state_ff == NIP_ST_LOAD);
      if (state_ff == NIP_ST_LOAD)
      begin
        if (rst_vec_ff)
          vector_addr_ff <= NIP_VEC_RST;
        else if (sel_trap_ff)
          vector_addr_ff <= NIP_VEC_TRAP;
        else
          vector_addr_ff <= NIP_VEC_BASE - {11'h000, sel_idx_ff, 1'b0};
      end
    end
  end

  // Current level bits and nesting depth
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cc_lvl_ff <= NIP_LVL_3;
      depth_ff  <= 4'h0;
    end
    else if (state_ff == NIP_ST_LOAD)
    begin
      if (rst_vec_ff || sel_trap_ff)
        cc_lvl_ff <= NIP_LVL_3;
      else
        cc_lvl_ff <= lvl_regs_ff[2*sel_idx_ff +: 2];
      if (!rst_vec_ff && depth_ff != 4'hF)
        depth_ff <= depth_ff + 4'h1;
    end
    else if (handler_return_instr_exec)
    begin
      cc_lvl_ff <= handler_return_instr_level;
      if (depth_ff != 4'h0)
        depth_ff <= depth_ff - 4'h1;
    end
  end

  assign hrdata         = hrdata_ff;
  assign hreadyout      = hreadyout_ff;
  assign hresp          = 1'b0;
  assign stack_push     = stack_push_ff;
  assign stack_item     = stack_item_ff;
  assign vector_load    = vector_load_ff;
  assign vector_addr    = vector_addr_ff;
  assign level_bit_high = cc_lvl_ff[1];
  assign level_bit_low  = cc_lvl_ff[0];
  assign entry_busy     = busy_ff;
  assign wake           = wake_ff;
endmodule

// file: rtl/nip_pkg.sv
// Shared constants and types for the nested priority interrupt controller
// Assumes a single clock domain and a 32-bit AHB-Lite register port
package nip_pkg;
  localparam int NIP_NVEC = 14;
  localparam int NIP_NEXT = 4;
  localparam int NIP_NPIN = 8;
  // Register byte offsets
  localparam logic [7:0] NIP_OFS_LVL0 = 8'h00;
  localparam logic [7:0] NIP_OFS_LVL1 = 8'h04;
  localparam logic [7:0] NIP_OFS_LVL2 = 8'h08;
  localparam logic [7:0] NIP_OFS_LVL3 = 8'h0C;
  localparam logic [7:0] NIP_OFS_EDGE = 8'h10;
  localparam logic [7:0] NIP_OFS_EN   = 8'h14;
  localparam logic [7:0] NIP_OFS_CTRL = 8'h18;
  localparam logic [7:0] NIP_OFS_PSEL = 8'h1C;
  localparam logic [7:0] NIP_OFS_STAT = 8'h20;
  localparam logic [7:0] NIP_OFS_WCAP = 8'h24;
  // Reset values
  localparam logic [31:0] NIP_RST_LVL  = 32'hFFFF_FFFF;
  localparam logic [3:0]  NIP_RST_EDGE = 4'h0;
  localparam logic [13:0] NIP_RST_EN   = 14'h0000;
  localparam logic        NIP_RST_NEST = 1'b1;
  localparam logic [7:0]  NIP_RST_PSEL = 8'hFF;
  localparam logic [13:0] NIP_RST_WCAP = 14'h000F;
  // Field positions
  localparam int NIP_CTRL_NEST = 0;
  localparam int NIP_STAT_LVL  = 16;
  localparam int NIP_STAT_DEP  = 20;
  localparam int NIP_STAT_BUSY = 24;
  // Level codes of the two priority bits
  localparam logic [1:0] NIP_LVL_0 = 2'b10;
  localparam logic [1:0] NIP_LVL_1 = 2'b01;
  localparam logic [1:0] NIP_LVL_2 = 2'b00;
  localparam logic [1:0] NIP_LVL_3 = 2'b11;
  // Vector addresses
  localparam logic [15:0] NIP_VEC_RST  = 16'hFFFE;
  localparam logic [15:0] NIP_VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] NIP_VEC_BASE = 16'hFFFA;
  // Stacked items, pushed in this order
  localparam logic [1:0] NIP_ITEM_PC = 2'b00;
  localparam logic [1:0] NIP_ITEM_X  = 2'b01;
  localparam logic [1:0] NIP_ITEM_A  = 2'b10;
  localparam logic [1:0] NIP_ITEM_CC = 2'b11;
  typedef enum logic [1:0] {
    NIP_ST_IDLE = 2'b00,
    NIP_ST_PUSH = 2'b01,
    NIP_ST_LOAD = 2'b10
  } nip_state_t;
  // Turns a level code into a rank 0..3
  function automatic logic [1:0] nip_rank(input logic [1:0] code);
    nip_rank = {~(code[1] ^ code[0]), code[0]};
  endfunction
endpackage

// file: rtl/nip_req_latch.sv
// Request latch for one vector, edge or level sensitive
// Assumes src is synchronous to clk
`timescale 1ns/1ps
module nip_req_latch
  import nip_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic src,
  input  wire logic edge_mode,
  input  wire logic clr_entry,
  input  wire logic clr_seq,
  output logic      pend
);
  logic src_d_ff;
  logic pend_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_d_ff <= 1'b0;
      pend_ff  <= 1'b0;
    end
    else
    begin
      src_d_ff <= src;
      if (edge_mode)
      begin
        if (src && !src_d_ff)
          pend_ff <= 1'b1;
        else if (clr_entry || clr_seq)
          pend_ff <= 1'b0;
      end
      else
        pend_ff <= src && !clr_seq;
    end
  end

  assign pend = pend_ff;
endmodule

// file: tb/nip_cpu_model.sv
// CPU core model: instruction boundaries, trap and return strobes
// Assumes bench requests are synchronous to clk
`timescale 1ns/1ps
module nip_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cpu_halt,
  input  wire logic       cpu_wait,
  input  wire logic       entry_busy,
  input  wire logic       do_trap,
  input  wire logic       do_handler_return_instr,
  input  wire logic [1:0] ret_lvl,
  output logic            instr_done,
  output logic            trap_exec,
  output logic            handler_return_instr_exec,
  output logic [1:0]      handler_return_instr_level
);
  logic [1:0] cnt_ff;
  logic       done_ff, trap_ff, handler_return_instr_ff;
  logic [1:0] lvl_ff;
  assign instr_done = done_ff;
  assign trap_exec  = trap_ff;
  assign handler_return_instr_exec  = handler_return_instr_ff;
  assign handler_return_instr_level = lvl_ff;
  // No instructions run in Halt, Wait or during entry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 2'h0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      done_ff <= (cnt_ff == 2'h3) && !cpu_halt && !cpu_wait && !entry_busy;
    end
  end
  // Trap instruction and popped level bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trap_ff <= 1'b0;
      handler_return_instr_ff <= 1'b0;
      lvl_ff <= 2'h3;
    end
    else
    begin
      trap_ff <= do_trap;
      handler_return_instr_ff <= do_handler_return_instr;
      lvl_ff <= ret_lvl;
    end
  end
endmodule

// file: tb/nip_ctrl_props.sv
// Port checker for the nested priority interrupt controller
// Assumes hready is looped back from hreadyout and one clock domain
`timescale 1ns/1ps
module nip_ctrl_props
  import nip_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        instr_done,
  input wire logic        handler_return_instr_exec,
  input wire logic [1:0]  handler_return_instr_level,
  input wire logic        stack_push,
  input wire logic [1:0]  stack_item,
  input wire logic        vector_load,
  input wire logic [15:0] vector_addr,
  input wire logic        level_bit_high,
  input wire logic        level_bit_low,
  input wire logic        entry_busy
);
  logic [1:0] lvl;
  assign lvl = {level_bit_high, level_bit_low};
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence push_seq;
    stack_push && stack_item == NIP_ITEM_PC ##1 stack_push && stack_item == NIP_ITEM_X
    ##1 stack_push && stack_item == NIP_ITEM_A ##1 stack_push && stack_item == NIP_ITEM_CC;
  endsequence
  entry_seq_a: assert property ($rose(entry_busy) |=> push_seq ##1 vector_load)
    else $error("entry sequence broken");
  entry_bound_a: assert property ($rose(entry_busy) |-> $past(instr_done))
    else $error("entry started off an instruction boundary");
  push_busy_a: assert property (stack_push |-> entry_busy)
    else $error("stack push outside entry");
  nmi_level_a: assert property (vector_load && vector_addr == NIP_VEC_TRAP |-> lvl == NIP_LVL_3)
    else $error("trap entry did not force level 3");
  no_main_a: assert property (vector_load |-> lvl != NIP_LVL_0)
    else $error("handler entered at main level");
  ret_level_a: assert property (handler_return_instr_exec |=> lvl == $past(handler_return_instr_level))
    else $error("return did not restore level");
  load_gap_a: assert property (vector_load |=> !vector_load [*5])
    else $error("vector loads too close");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule

bind nip_ctrl nip_ctrl_props u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .instr_done(instr_done),
  .handler_return_instr_exec(handler_return_instr_exec), .handler_return_instr_level(handler_return_instr_level), .stack_push(stack_push),
  .stack_item(stack_item), .vector_load(vector_load), .vector_addr(vector_addr),
  .level_bit_high(level_bit_high), .level_bit_low(level_bit_low), .entry_busy(entry_busy)
);

// file: tb/testbench.sv
// Self-checking bench for the interrupt controller
// Assumes the CPU model supplies boundaries; the bench plays the AHB master
`timescale 1ns/1ps
module testbench;
  import nip_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, do_trap, do_handler_return_instr, cpu_halt, cpu_wait;
  logic        hreadyout, hresp, instr_done, trap_exec, handler_return_instr_exec, stack_push;
  logic        vector_load, lvl_h, lvl_l, entry_busy, wake;
  logic [1:0]  htrans, ret_lvl, handler_return_instr_level, stack_item, lvl;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] vector_addr;
  logic [7:0]  ext_pin;
  logic [9:0]  periph_flag;
  logic [13:0] periph_clear;
  int          failures, n_tests;
  logic [7:0]  ra [8] = '{NIP_OFS_LVL0, NIP_OFS_LVL3, NIP_OFS_EDGE, NIP_OFS_EN,
                         NIP_OFS_CTRL, NIP_OFS_PSEL, NIP_OFS_WCAP, 8'h30};
  logic [31:0] rv [8] = '{32'h0000_00FF, 32'h0000_000F, 32'h0000_0000, 32'h0000_0000,
                         32'h0000_0001, 32'h0000_00FF, 32'h0000_000F, 32'h0000_0000};
  logic [2:0]  wk [3] = '{3'b100, 3'b001, 3'b111};
  assign lvl = {lvl_h, lvl_l};
  nip_ctrl DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_pin(ext_pin), .periph_flag(periph_flag),
    .periph_clear(periph_clear), .instr_done(instr_done), .trap_exec(trap_exec),
    .handler_return_instr_exec(handler_return_instr_exec), .handler_return_instr_level(handler_return_instr_level), .cpu_halt(cpu_halt), .cpu_wait(cpu_wait),
    .stack_push(stack_push), .stack_item(stack_item), .vector_load(vector_load),
    .vector_addr(vector_addr), .level_bit_high(lvl_h), .level_bit_low(lvl_l),
    .entry_busy(entry_busy), .wake(wake)
  );
  nip_cpu_model u_cpu (
    .clk(hclk), .rst_n(hresetn), .cpu_halt(cpu_halt), .cpu_wait(cpu_wait),
    .entry_busy(entry_busy), .do_trap(do_trap), .do_handler_return_instr(do_handler_return_instr), .ret_lvl(ret_lvl),
    .instr_done(instr_done), .trap_exec(trap_exec), .handler_return_instr_exec(handler_return_instr_exec),
    .handler_return_instr_level(handler_return_instr_level)
  );
  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wait_entry(input logic [15:0] va, input logic [1:0] lv);
    for (int i = 0; i < 300 && vector_load !== 1'b1; i++) @(posedge hclk);
    check("entry seen", vector_load, 1'b1);
    check("vector", vector_addr, va);
    check("entry level", lvl, lv);
  endtask
  task no_entry;
    int c;
    c = 0;
    repeat (24)
    begin
      @(posedge hclk);
      if (vector_load === 1'b1) c++;
    end
    check("no entry", c, 0);
  endtask
  task handler_return_instr(input logic [1:0] l);
    @(posedge hclk);
    do_handler_return_instr <= 1'b1;
    ret_lvl <= l;
    @(posedge hclk);
    do_handler_return_instr <= 1'b0;
    repeat (2) @(posedge hclk);
    check("return level", lvl, l);
  endtask
  task end_of_test;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #750000;
    failures++;
    end_of_test();
  end
  initial
  begin
    hresetn <= 1'b0;
    hsel <= 1'b1;
    hsize <= 3'b010;
    haddr <= 32'h0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    ext_pin <= 8'h00;
    periph_flag <= 10'h000;
    periph_clear <= 14'h0000;
    do_trap <= 1'b0;
    do_handler_return_instr <= 1'b0;
    ret_lvl <= NIP_LVL_0;
    cpu_halt <= 1'b0;
    cpu_wait <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check("reset fetch", vector_load, 1'b1);
    @(posedge hclk);
    check("reset vector", vector_addr, NIP_VEC_RST);
    check("reset level", lvl, NIP_LVL_3);
    bus(1'b1, 8'h30, 32'h0000_00FF, rd);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, ra[i], 32'h0, rd);
      check("reset reg", rd, rv[i]);
    end
    bus(1'b1, NIP_OFS_LVL0, 32'h0000_00CF, rd);
    bus(1'b1, NIP_OFS_LVL0, 32'h0000_0064, rd);
    bus(1'b0, NIP_OFS_LVL0, 32'h0, rd);
    check("level keep", rd, 32'h0000_0044);
    bus(1'b1, NIP_OFS_LVL0, 32'h0000_0051, rd);
    bus(1'b1, NIP_OFS_LVL1, 32'h0000_00F5, rd);
    @(posedge hclk) do_trap <= 1'b1;
    @(posedge hclk) do_trap <= 1'b0;
    wait_entry(NIP_VEC_TRAP, NIP_LVL_3);
    handler_return_instr(NIP_LVL_0);
    @(posedge hclk) ext_pin <= 8'h01;
    no_entry();
    bus(1'b0, NIP_OFS_STAT, 32'h0, rd);
    check("pending", rd[0], 1'b1);
    bus(1'b1, NIP_OFS_EN, 32'h0000_0037, rd);
    wait_entry(16'hFFFA, NIP_LVL_1);
    @(posedge hclk) ext_pin <= 8'h09;
    wait_entry(16'hFFF8, NIP_LVL_2);
    @(posedge hclk) ext_pin <= 8'h01;
    handler_return_instr(NIP_LVL_1);
    no_entry();
    handler_return_instr(NIP_LVL_0);
    wait_entry(16'hFFFA, NIP_LVL_1);
    @(posedge hclk) ext_pin <= 8'h00;
    handler_return_instr(NIP_LVL_0);
    @(posedge hclk) periph_flag <= 10'h003;
    wait_entry(16'hFFF2, NIP_LVL_1);
    @(posedge hclk) periph_flag <= 10'h002;
    periph_clear <= 14'h0010;
    @(posedge hclk) periph_clear <= 14'h0000;
    handler_return_instr(NIP_LVL_0);
    wait_entry(16'hFFF0, NIP_LVL_1);
    @(posedge hclk) periph_flag <= 10'h000;
    handler_return_instr(NIP_LVL_0);
    bus(1'b1, NIP_OFS_CTRL, 32'h0, rd);
    @(posedge hclk) ext_pin <= 8'h01;
    wait_entry(16'hFFFA, NIP_LVL_1);
    @(posedge hclk) ext_pin <= 8'h09;
    no_entry();
    @(posedge hclk) ext_pin <= 8'h00;
    handler_return_instr(NIP_LVL_0);
    bus(1'b1, NIP_OFS_CTRL, 32'h1, rd);
    bus(1'b1, NIP_OFS_EDGE, 32'h4, rd);
    @(posedge hclk) ext_pin <= 8'h10;
    @(posedge hclk) ext_pin <= 8'h00;
    wait_entry(16'hFFF6, NIP_LVL_1);
    handler_return_instr(NIP_LVL_0);
    no_entry();
    bus(1'b1, NIP_OFS_EN, 32'h0000_0033, rd);
    @(posedge hclk) ext_pin <= 8'h10;
    @(posedge hclk) ext_pin <= 8'h00;
    bus(1'b0, NIP_OFS_STAT, 32'h0, rd);
    check("edge latched", rd[2], 1'b1);
    @(posedge hclk) periph_clear <= 14'h0004;
    @(posedge hclk) periph_clear <= 14'h0000;
    bus(1'b0, NIP_OFS_STAT, 32'h0, rd);
    check("edge discarded", rd[2], 1'b0);
    bus(1'b1, NIP_OFS_EN, 32'h0000_0037, rd);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge hclk) cpu_halt <= wk[i][2];
      cpu_wait <= !wk[i][2];
      ext_pin <= {7'h0, wk[i][1]};
      periph_flag <= {9'h0, !wk[i][1]};
      repeat (4) @(posedge hclk);
      check("wake", wake, wk[i][0]);
      @(posedge hclk) cpu_halt <= 1'b0;
      cpu_wait <= 1'b0;
      wait_entry(wk[i][1] ? 16'hFFFA : 16'hFFF2, NIP_LVL_1);
      @(posedge hclk) ext_pin <= 8'h00;
      periph_flag <= 10'h000;
      handler_return_instr(NIP_LVL_0);
    end
    end_of_test();
  end
endmodule
